/* File: verilog/imbd_cfg.svh */
`ifndef IMBD_CFG_SVH
`define IMBD_CFG_SVH
// peripheral register region
`define IMBD_REG_LO      32'h0000_0000
`define IMBD_REG_HI      32'h0003_FFFF
// block 0 rom windows (long, normal, short)
`define IMBD_ROM0_L_LO   32'h0004_0000
`define IMBD_ROM0_L_HI   32'h0004_BFFF
`define IMBD_ROM0_N_LO   32'h0008_0000
`define IMBD_ROM0_N_HI   32'h0009_7FFF
`define IMBD_ROM0_S_LO   32'h0010_0000
`define IMBD_ROM0_S_HI   32'h0012_FFFF
// sram windows: block b, width long/normal/short
`define IMBD_B0_L_LO     32'h0004_C000
`define IMBD_B0_L_HI     32'h0004_EFFF
`define IMBD_B0_N_LO     32'h0009_8000
`define IMBD_B0_N_HI     32'h0009_DFFF
`define IMBD_B0_S_LO     32'h0013_0000
`define IMBD_B0_S_HI     32'h0013_BFFF
`define IMBD_B1_L_LO     32'h0005_C000
`define IMBD_B1_L_HI     32'h0005_EFFF
`define IMBD_B1_N_LO     32'h000B_8000
`define IMBD_B1_N_HI     32'h000B_DFFF
`define IMBD_B1_S_LO     32'h0017_0000
`define IMBD_B1_S_HI     32'h0017_BFFF
`define IMBD_B2_L_LO     32'h0006_0000
`define IMBD_B2_L_HI     32'h0006_0FFF
`define IMBD_B2_N_LO     32'h000C_0000
`define IMBD_B2_N_HI     32'h000C_1FFF
`define IMBD_B2_S_LO     32'h0018_0000
`define IMBD_B2_S_HI     32'h0018_3FFF
`define IMBD_B3_L_LO     32'h0007_0000
`define IMBD_B3_L_HI     32'h0007_0FFF
`define IMBD_B3_N_LO     32'h000E_0000
`define IMBD_B3_N_HI     32'h000E_1FFF
`define IMBD_B3_S_LO     32'h001C_0000
`define IMBD_B3_S_HI     32'h001C_3FFF
// top bit of the per-block halfword index
`define IMBD_HW_BITS     15
// 64-bit rows per bank: blocks 0 and 1, then blocks 2 and 3
`define IMBD_ROWS_BIG    32'h0000_3000
`define IMBD_ROWS_SMALL  32'h0000_1000
`define IMBD_PORTS       4
`endif

/* File: verilog/imbd_pkg.sv */
package imbd_pkg;
   // decoded target of an address
   typedef enum logic [3:0] {
      IMBD_T_NONE = 4'b0001,
      IMBD_T_REG  = 4'b0010,
      IMBD_T_ROM  = 4'b0100,
      IMBD_T_RAM  = 4'b1000
   } imbd_target_t;
   // access width, one-hot
   typedef enum logic [3:0] {
      IMBD_W16 = 4'b0001,
      IMBD_W32 = 4'b0010,
      IMBD_W48 = 4'b0100,
      IMBD_W64 = 4'b1000
   } imbd_width_t;
endpackage

/* File: verilog/imbd_internal_memory.sv */
// Function
// - lowest region goes to peripheral registers
// - block 0 windows, index scaled per width
// - block 1 windows, own bank sized as block 0
// - block 2 windows, a third of block 0 in size
// - block 3 windows, own bank sized as block 2
// - block 0 rom windows decode to rom
// - gaps reserved, never alias onto storage
// - core and io accesses complete independently on distinct blocks
// - two core plus two io per cycle
// - four buses to four blocks together
// - 16/32/64-bit access by window
// - sram totals two megabits over four blocks
`timescale 1ns/1ps
`default_nettype none
`include "imbd_cfg.svh"
module imbd_internal_memory
   import imbd_pkg::*;
(
   // request side: port 0 data bus, 1 program bus, 2 and 3 dma buses
   input  wire logic                mclk,
   input  wire logic                resetn,
   input  wire logic [3:0]          reqValid,   // 0 dm, 1 pm, 2 dma0, 3 dma1
   input  wire logic [3:0]          reqWrite,
   input  wire logic [127:0]        reqAddr,    // 4 x 32
   input  wire logic [255:0]        reqWdata,   // 4 x 64, low bits used
   // answer side: every flag and the read data come from flip-flops
   output logic      [3:0]          ackValid,   // access done this cycle
   output logic      [3:0]          ackStall,   // request held off
   output logic      [3:0]          ackError,   // reserved or rom hit
   output logic      [3:0]          ackRegion,  // routed to register file
   output logic      [255:0]        ackRdata
);
   // four banks of 64-bit rows, one per block, indexed by halfword / 4
   // blocks 0 and 1 carry three times the rows of blocks 2 and 3; each bank
   // is sized to its own windows so no legal index runs off its end
   // a row holds four halfwords, the lowest halfword in bits 15:0
   // contents are not reset: software must write a word before reading it
   logic [63:0] mem0 [`IMBD_ROWS_BIG];
   logic [63:0] mem1 [`IMBD_ROWS_BIG];
   logic [63:0] mem2 [`IMBD_ROWS_SMALL];
   logic [63:0] mem3 [`IMBD_ROWS_SMALL];

   // inclusive window test: both end addresses belong to the window
   function automatic logic inr(input logic [31:0] a, input logic [31:0] lo,
                                input logic [31:0] hi);
      inr = (a >= lo) && (a <= hi);
   endfunction

   // lanes a word of the given width covers, counted from bit 0
   // shared by the write merge and the read alignment
   function automatic logic [63:0] wmask(input logic [3:0] w);
      unique case (w)
         IMBD_W16: wmask = 64'h0000_0000_0000_FFFF;
         IMBD_W32: wmask = 64'h0000_0000_FFFF_FFFF;
         IMBD_W48: wmask = 64'h0000_FFFF_FFFF_FFFF;
         default:  wmask = 64'hFFFF_FFFF_FFFF_FFFF;
      endcase
   endfunction

   // decode: target, block, width and halfword index
   // packed result: target 25:22, width 21:18, block 17:16, index 15:0
   // no 48-bit view is decoded: its addresses overlap normal windows,
   // which win, or rom and reserved space, which is refused
   function automatic logic [25:0] dec(input logic [31:0] a);
      imbd_target_t t;     // what the address reaches
      imbd_width_t  w;     // access width of the window
      logic [1:0]   b;     // block number
      logic [31:0]  hw;    // halfword offset inside the block
      t  = IMBD_T_NONE;
      w  = IMBD_W32;
      b  = 2'd0;
      hw = 32'h0000_0000;
      // register region first, then block 0 rom, then the sram windows
      if (inr(a, `IMBD_REG_LO, `IMBD_REG_HI)) t = IMBD_T_REG;
      else if (inr(a, `IMBD_ROM0_L_LO, `IMBD_ROM0_L_HI) ||
               inr(a, `IMBD_ROM0_N_LO, `IMBD_ROM0_N_HI) ||
               inr(a, `IMBD_ROM0_S_LO, `IMBD_ROM0_S_HI)) t = IMBD_T_ROM;
      else if (inr(a, `IMBD_B0_L_LO, `IMBD_B0_L_HI)) begin
         t = IMBD_T_RAM; w = IMBD_W64; b = 2'd0;
         // halfword index: a long word spans four, a normal word two
         hw = (a - `IMBD_B0_L_LO) << 2;
      end else if (inr(a, `IMBD_B0_N_LO, `IMBD_B0_N_HI)) begin
         t = IMBD_T_RAM; b = 2'd0; hw = (a - `IMBD_B0_N_LO) << 1;
      end else if (inr(a, `IMBD_B0_S_LO, `IMBD_B0_S_HI)) begin
         t = IMBD_T_RAM; w = IMBD_W16; b = 2'd0; hw = a - `IMBD_B0_S_LO;
      end else if (inr(a, `IMBD_B1_L_LO, `IMBD_B1_L_HI)) begin
         t = IMBD_T_RAM; w = IMBD_W64; b = 2'd1;
         hw = (a - `IMBD_B1_L_LO) << 2;
      end else if (inr(a, `IMBD_B1_N_LO, `IMBD_B1_N_HI)) begin
         t = IMBD_T_RAM; b = 2'd1; hw = (a - `IMBD_B1_N_LO) << 1;
      end else if (inr(a, `IMBD_B1_S_LO, `IMBD_B1_S_HI)) begin
         t = IMBD_T_RAM; w = IMBD_W16; b = 2'd1; hw = a - `IMBD_B1_S_LO;
      end else if (inr(a, `IMBD_B2_L_LO, `IMBD_B2_L_HI)) begin
         t = IMBD_T_RAM; w = IMBD_W64; b = 2'd2;
         hw = (a - `IMBD_B2_L_LO) << 2;
      end else if (inr(a, `IMBD_B2_N_LO, `IMBD_B2_N_HI)) begin
         t = IMBD_T_RAM; b = 2'd2; hw = (a - `IMBD_B2_N_LO) << 1;
      end else if (inr(a, `IMBD_B2_S_LO, `IMBD_B2_S_HI)) begin
         t = IMBD_T_RAM; w = IMBD_W16; b = 2'd2; hw = a - `IMBD_B2_S_LO;
      end else if (inr(a, `IMBD_B3_L_LO, `IMBD_B3_L_HI)) begin
         t = IMBD_T_RAM; w = IMBD_W64; b = 2'd3;
         hw = (a - `IMBD_B3_L_LO) << 2;
      end else if (inr(a, `IMBD_B3_N_LO, `IMBD_B3_N_HI)) begin
         t = IMBD_T_RAM; b = 2'd3; hw = (a - `IMBD_B3_N_LO) << 1;
      end else if (inr(a, `IMBD_B3_S_LO, `IMBD_B3_S_HI)) begin
         t = IMBD_T_RAM; w = IMBD_W16; b = 2'd3; hw = a - `IMBD_B3_S_LO;
      end
      // every other address, gaps included, stays unmapped
      dec = {t, w, b, hw[`IMBD_HW_BITS:0]};
   endfunction

   // per-port decode and same-block arbitration
   logic [3:0]  isRam;         // port requests sram storage
   logic [3:0]  isReg;         // port requests the register region
   logic [3:0]  grant;         // port owns its block this cycle
   logic [1:0]  blk    [4];    // block each port addresses
   logic [15:0] hwIdx  [4];    // halfword index inside that block
   logic [3:0]  wid    [4];    // one-hot access width

   // one decoder per port; all four work side by side every cycle
   genvar p;
   generate
      for (p = 0; p < `IMBD_PORTS; p++) begin : g_dec
         logic [25:0] d;                     // packed decode of this port
         assign d        = dec(reqAddr[p*32 +: 32]);
         // hits only count while the port is requesting
         assign isRam[p] = reqValid[p] && d[25:22] == IMBD_T_RAM;
         assign isReg[p] = reqValid[p] && d[25:22] == IMBD_T_REG;
         // split the packed decode back into its fields
         assign wid[p]   = d[21:18];
         assign blk[p]   = d[17:16];
         assign hwIdx[p] = d[15:0];
      end
   endgenerate

   // lower port number wins a shared block; distinct blocks all go
   // fixed order is cheap, but a port that keeps hitting one block holds
   // off every higher port on it, so software spreads its streams
   always_comb begin
      for (int i = 0; i < `IMBD_PORTS; i++) begin
         grant[i] = isRam[i];
         // any lower port already on this block takes it
         for (int j = 0; j < i; j++)
            if (isRam[j] && blk[j] == blk[i]) grant[i] = 1'b0;
      end
   end

   // storage write for granted ports, one cycle each
   // each port writes its own block, so the four merges never collide
   always_ff @(posedge mclk) begin
      for (int i = 0; i < `IMBD_PORTS; i++) begin
         if (grant[i] && reqWrite[i]) begin
            logic [13:0] r;      // row within the bank
            logic [1:0]  h;      // halfword within the row
            logic [63:0] old;    // row as it stands
            logic [63:0] m;      // lanes this write may touch
            logic [63:0] nv;     // merged row
            r = hwIdx[i][15:2];
            h = hwIdx[i][1:0];
            // read-modify-write keeps the lanes outside the word intact
            unique case (blk[i])
               2'd0: old = mem0[r];
               2'd1: old = mem1[r];
               2'd2: old = mem2[r[11:0]];
               default: old = mem3[r[11:0]];
            endcase
            // long words always start a row, so h is 0 for them
            m = wmask(wid[i]) << (h*16);
            nv = (old & ~m) | ((reqWdata[i*64 +: 64] << (h*16)) & m);
            // write back into the one bank this port was granted
            unique case (blk[i])
               2'd0: mem0[r] <= nv;
               2'd1: mem1[r] <= nv;
               2'd2: mem2[r[11:0]] <= nv;
               default: mem3[r[11:0]] <= nv;
            endcase
         end
      end
   end

   // read data, aligned to low bits and cut to the access width
   // lanes above the word read as zero, so a short read never shows its
   // neighbours; a write or a stalled port leaves the last data standing
   always_ff @(posedge mclk) begin
      for (int i = 0; i < `IMBD_PORTS; i++) begin
         logic [63:0] row;   // row of the block this port addresses
         row = 64'h0;
         unique case (blk[i])
            2'd0: row = mem0[hwIdx[i][15:2]];
            2'd1: row = mem1[hwIdx[i][15:2]];
            2'd2: row = mem2[hwIdx[i][13:2]];
            default: row = mem3[hwIdx[i][13:2]];
         endcase
         if (!resetn) begin
            ackRdata[i*64 +: 64] <= 64'h0;    // no stale data after reset
         end else if (grant[i] && !reqWrite[i]) begin
            ackRdata[i*64 +: 64] <= (row >> (hwIdx[i][1:0]*16)) &
                                    wmask(wid[i]);
         end
      end
   end

   // handshake flags; a stalled port simply retries next cycle
   // every flag follows its request by exactly one cycle and stands one
   // cycle; reset clears them all so no answer follows reset
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ackValid  <= 4'h0;
         ackStall  <= 4'h0;
         ackError  <= 4'h0;
         ackRegion <= 4'h0;
      end else begin
         // a register-region hit is answered here; its data lives elsewhere
         ackValid  <= grant | isReg;
         // a loser is told so it can re-present the same request
         ackStall  <= isRam & ~grant;
         // rom, gap and unmapped hits are refused, nothing is written
         ackError  <= reqValid & ~isRam & ~isReg;
         ackRegion <= isReg;
      end
   end
endmodule
`default_nettype wire

/* File: verif/imbd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the four request ports and their one-cycle answers
module imbd_checker (
   input wire logic         mclk,
   input wire logic         resetn,
   input wire logic [3:0]   reqValid,
   input wire logic [127:0] reqAddr,
   input wire logic [3:0]   ackValid,
   input wire logic [3:0]   ackStall,
   input wire logic [3:0]   ackError,
   input wire logic [3:0]   ackRegion
);
   // port 0 wins every clash, so its answer follows its address alone
   wire logic [31:0] a0 = reqAddr[31:0];
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_reg_route: assert property (
      reqValid[0] && a0 <= 32'h0003_FFFF |=> ackRegion[0] && !ackError[0])
      else $error("register region not routed");
   a_rom_refuse: assert property (
      reqValid[0] && a0 >= 32'h0004_0000 && a0 <= 32'h0004_BFFF
      |=> ackError[0] && !ackValid[0]) else $error("rom access not refused");
   a_gap_refuse: assert property (
      reqValid[0] && a0 >= 32'h0004_F000 && a0 <= 32'h0004_FFFF
      |=> ackError[0] && !ackValid[0]) else $error("gap access not refused");
   a_blk0_done: assert property (
      reqValid[0] && a0 >= 32'h0004_C000 && a0 <= 32'h0004_EFFF
      |=> ackValid[0] && !ackError[0]) else $error("block 0 access lost");
   a_top_wins: assert property (!ackStall[0])
      else $error("top priority port stalled");
   a_stall_cause: assert property (
      ackStall[2] |-> $past(reqValid[2]) && $past(|reqValid[1:0]))
      else $error("stall without a rival");
   a_done_cause: assert property (ackValid[1] |-> $past(reqValid[1]))
      else $error("answer without request");
   a_idle_quiet: assert property (
      !reqValid[2] |=> !(ackValid[2] || ackStall[2] || ackError[2]))
      else $error("answer on idle port");
   a_flag_excl: assert property ((ackStall & ackValid) == 4'h0)
      else $error("port both stalled and served");
   cover property (ackValid == 4'hF);
   cover property (|ackStall);
   cover property (|ackRegion);
endmodule
`default_nettype wire

/* File: verif/imbd_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// stands for the core and dma buses; a stalled request is offered again
module imbd_bus_model (
   input  wire logic         mclk,
   input  wire logic [3:0]   go,
   input  wire logic [3:0]   wr,
   input  wire logic [127:0] ad,
   input  wire logic [255:0] wd,
   input  wire logic [3:0]   ackStall,
   output var  logic [3:0]   reqValid = 4'h0,
   output var  logic [3:0]   reqWrite = 4'h0,
   output var  logic [127:0] reqAddr = '0,
   output var  logic [255:0] reqWdata = '0
);
   // launch on the edge; address and data hold so a retry needs no resend
   always @(posedge mclk) begin
      reqValid <= go | ackStall;
      if (|go) begin
         reqWrite <= wr;
         reqAddr  <= ad;
         reqWdata <= wd;
      end
   end
endmodule
`default_nettype wire

/* File: verif/imbd_internal_memory_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module imbd_internal_memory_bench;
   logic         mclk = 1'b0;
   logic         resetn = 1'b0;
   logic [3:0]   go = 4'h0;
   logic [3:0]   wr = 4'h0;
   logic [127:0] ad = '0;
   logic [255:0] wd = '0;
   logic [3:0]   reqValid, reqWrite, ackValid, ackStall, ackError, ackRegion;
   logic [127:0] reqAddr;
   logic [255:0] reqWdata, ackRdata;
   int           nMismatch = 0;
   int           cmpCount = 0;
   int           cyc = 0;
   // one long word window per block, port p to block p
   localparam logic [127:0] FOUR = {32'h0007_0000, 32'h0006_0000,
                                    32'h0005_C000, 32'h0004_C000};
   always #2 mclk = ~mclk;
   imbd_bus_model u_imbd_bus_model (.mclk(mclk), .go(go), .wr(wr), .ad(ad),
      .wd(wd), .ackStall(ackStall), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata));
   imbd_internal_memory u_imbd_internal_memory (.mclk(mclk),
      .resetn(resetn), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqWdata(reqWdata), .ackValid(ackValid),
      .ackStall(ackStall), .ackError(ackError), .ackRegion(ackRegion),
      .ackRdata(ackRdata));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nMismatch++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("mismatches %0d compares %0d", nMismatch, cmpCount);
      if (nMismatch == 0 && cmpCount > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one request cycle; the answer is read one cycle after the model launches
   task automatic acc(input logic [3:0] g, input logic [3:0] w,
                      input logic [127:0] a, input logic [255:0] d);
      @(posedge mclk);
      go <= g; wr <= w; ad <= a; wd <= d;
      @(posedge mclk);
      go <= 4'h0;
      @(posedge mclk);
      #1;
   endtask
   // register region, rom and gap on port 0
   task automatic t_decode;
      acc(4'h1, 4'h0, {96'h0, 32'h0000_0100}, '0);
      chk({ackRegion, ackValid}, 8'h11);
      acc(4'h1, 4'h0, {96'h0, 32'h0004_0000}, '0);
      chk(ackError, 4'h1);
      acc(4'h1, 4'h0, {96'h0, 32'h0004_F000}, '0);
      chk({ackError, ackValid}, 8'h10);
   endtask
   // long word in, short and normal words back out of the same row
   task automatic t_width;
      acc(4'h1, 4'h1, {96'h0, 32'h0004_C000},
          {192'h0, 64'h1122_3344_5566_7788});
      chk(ackValid, 4'h1);
      acc(4'h1, 4'h0, {96'h0, 32'h0013_0001}, '0);
      chk(ackRdata[63:0], 64'h5566);
      acc(4'h1, 4'h0, {96'h0, 32'h0009_8001}, '0);
      chk(ackRdata[63:0], 64'h1122_3344);
      // last long word of block 0, read back as its lowest short word
      acc(4'h1, 4'h1, {96'h0, 32'h0004_EFFF},
          {192'h0, 64'hA5A5_0000_0000_1234});
      chk(ackValid, 4'h1);
      acc(4'h1, 4'h0, {96'h0, 32'h0013_BFFC}, '0);
      chk(ackRdata[63:0], 64'h1234);
   endtask
   // all four ports on four blocks in one cycle, data kept apart
   task automatic t_four;
      acc(4'hF, 4'hF, FOUR, {64'hD3, 64'hD2, 64'hD1, 64'hD0});
      chk(ackValid, 4'hF);
      acc(4'hF, 4'h0, FOUR, '0);
      chk(ackValid, 4'hF);
      chk(ackRdata[255:192], 64'hD3);
      chk(ackRdata[191:128], 64'hD2);
      chk(ackRdata[127:64], 64'hD1);
      chk(ackRdata[63:0], 64'hD0);
   endtask
   // ports 0 and 2 on one block: port 2 waits, then is served
   task automatic t_clash;
      acc(4'h5, 4'h0, {32'h0, 32'h0004_C000, 32'h0, 32'h0004_C000}, '0);
      chk({ackStall, ackValid}, 8'h41);
      @(posedge mclk);
      @(posedge mclk);
      #1;
      chk(ackValid, 4'h4);
      chk(ackRdata[191:128], 64'hD0);
   endtask
   // cut a hang short
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         nMismatch++;
         finish_test;
      end
   end
   initial begin
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      t_decode;
      t_width;
      t_four;
      t_clash;
      finish_test;
   end
endmodule
bind imbd_internal_memory imbd_checker u_imbd_checker (.mclk(mclk),
   .resetn(resetn), .reqValid(reqValid), .reqAddr(reqAddr),
   .ackValid(ackValid), .ackStall(ackStall), .ackError(ackError),
   .ackRegion(ackRegion));
`default_nettype wire
